// File: verilog/flags_segment_control_state.sv
// Status flags, segment selectors with hidden descriptors, and control registers
`timescale 1ns/1ps
`include "flags_segment_consts.svh"
module flags_segment_control_state #(
   parameter int SEG_N = `SEG_COUNT
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Arithmetic operation
   input wire logic aluValid,
   input wire logic [31:0] opA,
   input wire logic [31:0] opB,
   input wire logic isSub,
   input wire flags_segment_pkg::op_size_t opSize,
   output logic [31:0] aluResult_r,
   output flags_segment_pkg::status_flags_t statusFlags_r,
   output logic [31:0] flagsImage,
   // Selector load and store
   input wire logic segLoad,
   input wire logic [2:0] segLoadIdx,
   input wire logic [15:0] segLoadSel,
   input wire flags_segment_pkg::seg_desc_t segLoadDesc,
   input wire logic [2:0] segReadIdx,
   output logic [15:0] segReadSel_r,
   // Memory reference
   input wire logic memValid,
   input wire flags_segment_pkg::ref_kind_t memKind,
   input wire logic [2:0] memDataSeg,
   input wire logic [31:0] memOffset,
   input wire logic [2:0] memLen,
   output logic memDone_r,
   output logic [31:0] linearAddr_r,
   output logic limitFault_r,
   output logic attrFault_r,
   output logic [7:0] faultVector_r,
   // Control register load and store
   input wire flags_segment_pkg::ctrl_op_t ctrlOp,
   input wire logic [1:0] ctrlIdx,
   input wire logic [31:0] ctrlWrData,
   output logic [31:0] ctrlRdData_r,
   // Mode outputs
   output logic protMode,
   output logic pagingEnable
);

   // Fetches and stack traffic are pinned to their own selectors
   function automatic logic [2:0] segFor(flags_segment_pkg::ref_kind_t k,
                                         logic [2:0] dataSeg);
      case (k)
         flags_segment_pkg::REF_FETCH: segFor = `SEG_CODE_IDX;
         flags_segment_pkg::REF_STACK: segFor = `SEG_STACK_IDX;
         default: segFor = dataSeg;
      endcase
   endfunction : segFor

   function automatic flags_segment_pkg::seg_desc_t realDesc(logic [15:0] sel);
      realDesc.base = {12'h000, sel, 4'h0};
      realDesc.limit = `REAL_SEG_LIMIT;
      realDesc.attr = '{present: 1'b1, isCode: 1'b0, writable: 1'b1, readable: 1'b1};
   endfunction : realDesc

   // Architectural state
   logic [15:0] selector_r [SEG_N];
   flags_segment_pkg::seg_desc_t desc_r [SEG_N];
   logic [31:0] ctrlWord_r;
   logic [31:0] faultAddr_r;
   logic [31:0] dirBase_r;

   // Flag computation
   logic [31:0] aluResult;
   flags_segment_pkg::status_flags_t aluFlags;

   status_flag_unit #(.DATA_W(32)) flagUnit (
      .opA(opA),
      .opB(opB),
      .isSub(isSub),
      .opSize(opSize),
      .result(aluResult),
      .flags(aluFlags)
   );

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aluResult_r <= 32'h00000000;
         statusFlags_r <= '0;
      end else if (aluValid) begin
         aluResult_r <= aluResult;
         statusFlags_r <= aluFlags;
      end
   end

   assign flagsImage = {25'h0, statusFlags_r.zero, 1'b0, statusFlags_r.nibble, 1'b0,
                        statusFlags_r.parity, 1'b0, statusFlags_r.carry};

   // Mode decode
   assign protMode = ctrlWord_r[`CTRL_WORD_PROTECT_BIT];
   assign pagingEnable = ctrlWord_r[`CTRL_WORD_PAGING_BIT];

   // Descriptor cache load: real mode keeps the fixed limit and attributes
   wire flags_segment_pkg::seg_desc_t loadDesc = protMode ? segLoadDesc
                                                          : realDesc(segLoadSel);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < SEG_N; i++) begin
            selector_r[i] <= `SEL_RESET;
            desc_r[i] <= realDesc(`SEL_RESET);
         end
      end else if (segLoad && (segLoadIdx < 3'(SEG_N))) begin
         selector_r[segLoadIdx] <= segLoadSel;
         desc_r[segLoadIdx] <= loadDesc;
      end
   end

   // Only the selector is readable; the descriptor cache stays hidden
   wire logic [15:0] selReadNxt = (segReadIdx < 3'(SEG_N)) ? selector_r[segReadIdx] : 16'h0000;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) segReadSel_r <= 16'h0000;
      else segReadSel_r <= selReadNxt;
   end

   // Memory reference
   wire logic [2:0] memSeg = segFor(memKind, memDataSeg);
   wire logic segOk = (memSeg < 3'(SEG_N));
   wire flags_segment_pkg::seg_desc_t memDesc = segOk ? desc_r[memSeg] : '0;
   logic [31:0] linearAddr;
   logic limitFault;
   logic attrFault;

   segment_check_unit checkUnit (
      .desc(memDesc),
      .offset(memOffset),
      .accLen(memLen),
      .refKind(memKind),
      .protMode(protMode),
      .linearAddr(linearAddr),
      .limitFault(limitFault),
      .attrFault(attrFault)
   );

   // Out-of-range selector index counts as an attribute refusal
   wire logic attrFaultAll = attrFault || !segOk;
   wire logic anyFault = limitFault || attrFaultAll;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         memDone_r <= 1'b0;
         linearAddr_r <= 32'h00000000;
         limitFault_r <= 1'b0;
         attrFault_r <= 1'b0;
         faultVector_r <= 8'h00;
      end else begin
         memDone_r <= memValid;
         if (memValid) begin
            linearAddr_r <= linearAddr;
            limitFault_r <= limitFault;
            attrFault_r <= attrFaultAll;
            faultVector_r <= anyFault ? `LIMIT_FAULT_VECTOR : 8'h00;
         end
      end
   end

   // Control registers
   wire logic isLoad = (ctrlOp == flags_segment_pkg::CTRL_LOAD);
   wire logic isHalfLoad = (ctrlOp == flags_segment_pkg::HALF_LOAD);
   wire logic [31:0] fullWord = ctrlWrData & `CTRL_WORD_DEFINED_MASK;
   // Halfword load keeps the upper half and can only raise protection enable
   wire logic [15:0] halfLow = (ctrlWrData[15:0] & 16'(`CTRL_WORD_DEFINED_MASK)) |
                               {15'h0000, ctrlWord_r[`CTRL_WORD_PROTECT_BIT]};
   wire logic [31:0] halfWord = {ctrlWord_r[31:16], halfLow};
   wire logic [31:0] ctrlWord_nxt = (isLoad && ctrlIdx == `CR_IDX_CONTROL) ? fullWord :
                                    isHalfLoad ? halfWord : ctrlWord_r;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrlWord_r <= `CTRL_WORD_RESET;
         faultAddr_r <= 32'h00000000;
         dirBase_r <= 32'h00000000;
      end else begin
         ctrlWord_r <= ctrlWord_nxt;
         if (isLoad && ctrlIdx == `CR_IDX_FAULT_ADDR) faultAddr_r <= ctrlWrData;
         if (isLoad && ctrlIdx == `CR_IDX_DIR_BASE) dirBase_r <= ctrlWrData & `CR3_ADDR_MASK;
      end
   end

   wire logic [31:0] ctrlSel = (ctrlIdx == `CR_IDX_CONTROL) ? ctrlWord_r :
                               (ctrlIdx == `CR_IDX_FAULT_ADDR) ? faultAddr_r :
                               (ctrlIdx == `CR_IDX_DIR_BASE) ? dirBase_r : 32'h00000000;
   wire logic [31:0] ctrlRd_nxt =
      (ctrlOp == flags_segment_pkg::CTRL_STORE) ? ctrlSel :
      (ctrlOp == flags_segment_pkg::HALF_STORE) ? {16'h0000, ctrlWord_r[15:0]} :
      ctrlRdData_r;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) ctrlRdData_r <= 32'h00000000;
      else ctrlRdData_r <= ctrlRd_nxt;
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   zero_flag_a: assert property (
      aluValid |=> statusFlags_r.zero == (aluResult_r == 32'h00000000))
      else $error("zero flag disagrees with result");

   parity_flag_a: assert property (
      aluValid |=> statusFlags_r.parity == ~^aluResult_r[7:0])
      else $error("parity flag disagrees with low byte");

   byte_carry_a: assert property (
      aluValid && !isSub && opSize == flags_segment_pkg::SIZE8 && opA[7:0] == 8'hFF
      && opB[7:0] == 8'h01 |=> statusFlags_r.carry && statusFlags_r.zero)
      else $error("byte carry not flagged");

   nibble_carry_a: assert property (
      aluValid && !isSub && opA[3:0] == 4'hF && opB[3:0] == 4'h1
      |=> statusFlags_r.nibble)
      else $error("nibble carry not flagged");

   real_base_a: assert property (
      segLoad && !protMode && segLoadIdx < 3'(SEG_N) |=>
      desc_r[$past(segLoadIdx)].base == {12'h000, $past(segLoadSel), 4'h0}
      && desc_r[$past(segLoadIdx)].limit == `REAL_SEG_LIMIT)
      else $error("real mode base not selector times sixteen");

   half_keep_prot_a: assert property (
      isHalfLoad && protMode |=> protMode)
      else $error("halfword load cleared protection enable");

   half_upper_a: assert property (
      isHalfLoad |=> ctrlWord_r[31:16] == $past(ctrlWord_r[31:16]))
      else $error("halfword load changed upper bits");

   paging_load_a: assert property (
      isLoad && ctrlIdx == `CR_IDX_CONTROL |=> pagingEnable == $past(ctrlWrData[31]))
      else $error("paging enable does not follow control load");

   fault_vector_a: assert property (
      memValid && limitFault |=> limitFault_r && faultVector_r == `LIMIT_FAULT_VECTOR)
      else $error("limit fault not reported as vector 13");

   linear_addr_a: assert property (
      memValid |=> memDone_r && linearAddr_r == $past(memDesc.base) + $past(memOffset))
      else $error("linear address not base plus offset");

   nibble_borrow_a: assert property (
      aluValid && isSub && opA[3:0] == 4'h0 && opB[3:0] == 4'h1 |=> statusFlags_r.nibble)
      else $error("nibble borrow not flagged");

   word_carry_a: assert property (
      aluValid && !isSub && opSize == flags_segment_pkg::SIZE16 && opA[15:0] == 16'h8000
      && opB[15:0] == 16'h8000 |=> statusFlags_r.carry && statusFlags_r.zero)
      else $error("word carry not flagged");

   dword_borrow_a: assert property (
      aluValid && isSub && opSize == flags_segment_pkg::SIZE32
      |=> statusFlags_r.carry == $past(opA < opB))
      else $error("doubleword borrow flag wrong");

   flag_hold_a: assert property (
      !aluValid |=> $stable(statusFlags_r) && $stable(aluResult_r))
      else $error("flags changed without an operation");

   sel_load_a: assert property (
      segLoad && segLoadIdx < 3'(SEG_N) |=>
      selector_r[$past(segLoadIdx)] == $past(segLoadSel))
      else $error("selector not loaded");

   prot_desc_a: assert property (
      segLoad && protMode && segLoadIdx < 3'(SEG_N) |=>
      desc_r[$past(segLoadIdx)] == $past(segLoadDesc))
      else $error("protected load did not copy descriptor");

   code_fetch_a: assert property (
      memValid && memKind == flags_segment_pkg::REF_FETCH |=>
      linearAddr_r == $past(desc_r[`SEG_CODE_IDX].base) + $past(memOffset))
      else $error("fetch not based on code selector");

   stack_ref_a: assert property (
      memValid && memKind == flags_segment_pkg::REF_STACK |=>
      linearAddr_r == $past(desc_r[`SEG_STACK_IDX].base) + $past(memOffset))
      else $error("stack reference not based on stack selector");

   wrap_fault_a: assert property (
      memValid && ({1'b0, memOffset} + {30'h0, memLen}) > 33'h100000000 |=> limitFault_r)
      else $error("wrapping access not refused");

   prot_load_a: assert property (
      isLoad && ctrlIdx == `CR_IDX_CONTROL |=> protMode == $past(ctrlWrData[0]))
      else $error("protection enable does not follow control load");

   defined_bits_a: assert property (
      isLoad && ctrlIdx == `CR_IDX_CONTROL |=>
      ctrlWord_r == ($past(ctrlWrData) & `CTRL_WORD_DEFINED_MASK))
      else $error("control word holds undefined bits");

   half_store_a: assert property (
      ctrlOp == flags_segment_pkg::HALF_STORE |=>
      ctrlRdData_r == {16'h0000, $past(ctrlWord_r[15:0])})
      else $error("halfword store not low half of control word");

   done_pulse_a: assert property (
      !memValid |=> !memDone_r)
      else $error("reference done without a reference");
endmodule : flags_segment_control_state

// File: verilog/flags_segment_consts.svh
// Constants for the flags, segment and machine control state block
// Behaviour
// - Zero flag is 1 exactly when every result bit is 0.
// - Nibble carry flag reflects carry out of or borrow into bit 3.
// - Parity flag is 1 when low result byte holds even count of ones.
// - Carry flag reflects carry or borrow at bit 7, 15 or 31 by size.
// - Six 16-bit segment selector registers name the addressable segments.
// - Protected segments span one byte to 4 Gbytes; real mode caps 64 Kbytes.
// - A wrapping access on a maximum-limit segment raises limit fault 13.
// - Fetches use code selector, stack uses stack selector, others are data.
// - Each selector has hidden base, limit and attributes, invisible to software.
// - Real mode selector load sets base to selector shifted left four, limit and attributes to fixed values.
// - Protected mode selector load fills base, limit, attributes from descriptor.
// - Each reference adds hidden base, checks limit and checks attributes; the code checks attributes in protected mode only.
// - Three 32-bit control registers are loaded and stored by instructions.
// - Machine control word implements six defined control and status bits.
// - Low 16 bits form the status halfword used by halfword load/store.
// - Status halfword load leaves the upper 16 bits unchanged.
// - Paging unit is enabled while paging enable bit is 1.
// - Protected mode while protection enable bit is 1, else real mode.
// - Status halfword load may set but never clear protection enable.
`ifndef FLAGS_SEGMENT_CONSTS_SVH
`define FLAGS_SEGMENT_CONSTS_SVH

`define CR_IDX_CONTROL 2'h0
`define CR_IDX_FAULT_ADDR 2'h2
`define CR_IDX_DIR_BASE 2'h3
`define CTRL_WORD_PAGING_BIT 31
`define CTRL_WORD_PROTECT_BIT 0
`define CTRL_WORD_DEFINED_MASK 32'h8000001F
`define CTRL_WORD_RESET 32'h00000000
`define CR3_ADDR_MASK 32'hFFFFF000
`define SEG_CODE_IDX 3'h0
`define SEG_STACK_IDX 3'h1
`define SEG_COUNT 6
`define REAL_SEG_LIMIT 32'h0000FFFF
`define SEL_RESET 16'h0000
`define LIMIT_FAULT_VECTOR 8'h0D
`define FLAG_ZERO_BIT 6
`define FLAG_NIBBLE_BIT 4
`define FLAG_PARITY_BIT 2
`define FLAG_CARRY_BIT 0

`endif

// File: verilog/flags_segment_pkg.sv
// Types shared by the flags, segment and machine control state block
package flags_segment_pkg;
   typedef enum logic [1:0] {SIZE8, SIZE16, SIZE32} op_size_t;
   typedef enum logic [1:0] {REF_FETCH, REF_STACK, REF_READ, REF_WRITE} ref_kind_t;
   typedef enum logic [2:0] {CTRL_NONE, CTRL_LOAD, CTRL_STORE, HALF_LOAD, HALF_STORE} ctrl_op_t;
   typedef struct packed {
      logic zero;
      logic nibble;
      logic parity;
      logic carry;
   } status_flags_t;
   typedef struct packed {
      logic present;
      logic isCode;
      logic writable;
      logic readable;
   } seg_attr_t;
   typedef struct packed {
      logic [31:0] base;
      logic [31:0] limit;
      seg_attr_t attr;
   } seg_desc_t;
endpackage : flags_segment_pkg

// File: verilog/status_flag_unit.sv
// Add/subtract datapath slice that derives the four arithmetic status flags
`timescale 1ns/1ps
module status_flag_unit #(
   parameter int DATA_W = 32
) (
   // Operands
   input wire logic [DATA_W-1:0] opA,
   input wire logic [DATA_W-1:0] opB,
   input wire logic isSub,
   input wire flags_segment_pkg::op_size_t opSize,
   // Result
   output logic [DATA_W-1:0] result,
   output flags_segment_pkg::status_flags_t flags
);
   function automatic logic [DATA_W-1:0] sizeMask(flags_segment_pkg::op_size_t s);
      case (s)
         flags_segment_pkg::SIZE8: sizeMask = DATA_W'(32'h000000FF);
         flags_segment_pkg::SIZE16: sizeMask = DATA_W'(32'h0000FFFF);
         default: sizeMask = '1;
      endcase
   endfunction : sizeMask

   wire logic [DATA_W:0] sumFull = isSub ? ({1'b0, opA} - {1'b0, opB})
                                         : ({1'b0, opA} + {1'b0, opB});
   // Carry into bit k is a^b^s at k; serves add and borrow alike
   wire logic [DATA_W:0] carryIn = {1'b0, opA} ^ {1'b0, opB} ^ sumFull;
   wire logic [DATA_W-1:0] masked = sumFull[DATA_W-1:0] & sizeMask(opSize);
   wire logic carrySel = (opSize == flags_segment_pkg::SIZE8) ? carryIn[8] :
                         (opSize == flags_segment_pkg::SIZE16) ? carryIn[16] :
                         carryIn[DATA_W];

   assign result = masked;
   assign flags = '{zero: (masked == '0),
                    nibble: carryIn[4],
                    parity: ~^masked[7:0],
                    carry: carrySel};
endmodule : status_flag_unit

// File: verilog/segment_check_unit.sv
// Linear address formation with limit and attribute checks for one reference
`timescale 1ns/1ps
module segment_check_unit (
   // Reference
   input wire flags_segment_pkg::seg_desc_t desc,
   input wire logic [31:0] offset,
   input wire logic [2:0] accLen,
   input wire flags_segment_pkg::ref_kind_t refKind,
   input wire logic protMode,
   // Outcome
   output logic [31:0] linearAddr,
   output logic limitFault,
   output logic attrFault
);
   wire logic [32:0] lastByte = {1'b0, offset} + {30'h0, accLen} - 33'h1;
   // A carry past bit 31 means the access wraps, even when limit is all ones
   wire logic wraps = lastByte[32];
   wire logic overLimit = (lastByte[31:0] > desc.limit);
   wire logic isWrite = (refKind == flags_segment_pkg::REF_WRITE) ||
                        (refKind == flags_segment_pkg::REF_STACK);
   wire logic isFetch = (refKind == flags_segment_pkg::REF_FETCH);
   wire logic badKind = isFetch ? !desc.attr.isCode :
                        isWrite ? (desc.attr.isCode || !desc.attr.writable) :
                        (desc.attr.isCode && !desc.attr.readable);

   assign linearAddr = desc.base + offset;
   assign limitFault = wraps || overLimit;
   // Real mode attributes are fixed and never refuse a reference
   assign attrFault = protMode && (!desc.attr.present || badKind);
endmodule : segment_check_unit

// File: dv/descriptor_table_model.sv
// Descriptor table lookup standing in for the execution datapath
`timescale 1ns/1ps
module descriptor_table_model (
   // Lookup
   input wire logic [15:0] sel,
   // Descriptor
   output flags_segment_pkg::seg_desc_t desc
);
   // Unknown indexes give a not-present descriptor, as an empty table slot would
   always_comb begin
      case (sel[15:3])
         13'h1: desc = {32'h00100000, 32'h00000FFF, 4'b1101};
         13'h2: desc = {32'h00000004, 32'hFFFFFFFF, 4'b1011};
         default: desc = '0;
      endcase
   end
endmodule : descriptor_table_model

// File: dv/flags_segment_control_state_bench.sv
// Self-checking bench for the flags, segment and control state block
`timescale 1ns/1ps
module flags_segment_control_state_bench;
   logic clk_sys = 0, reset_n = 0, aluValid = 0, isSub = 0, segLoad = 0, memValid = 0;
   logic [31:0] opA = 0, opB = 0, memOffset = 0, ctrlWrData = 0;
   logic [31:0] aluResult_r, flagsImage, linearAddr_r, ctrlRdData_r;
   logic [2:0] segLoadIdx = 0, segReadIdx = 0, memDataSeg = 0, memLen = 1;
   logic [15:0] segLoadSel = 0, segReadSel_r;
   logic [1:0] ctrlIdx = 0;
   logic memDone_r, limitFault_r, attrFault_r, protMode, pagingEnable;
   logic [7:0] faultVector_r;
   flags_segment_pkg::op_size_t opSize = flags_segment_pkg::SIZE8;
   flags_segment_pkg::status_flags_t statusFlags_r;
   flags_segment_pkg::seg_desc_t segLoadDesc;
   flags_segment_pkg::ref_kind_t memKind = flags_segment_pkg::REF_READ;
   flags_segment_pkg::ctrl_op_t ctrlOp = flags_segment_pkg::CTRL_NONE;
   int mismatches = 0, n_tests = 0;

   always #50 clk_sys = ~clk_sys;

   descriptor_table_model table_i (.sel(segLoadSel), .desc(segLoadDesc));
   flags_segment_control_state DUT (.clk_sys(clk_sys), .reset_n(reset_n), .aluValid(aluValid),
      .opA(opA), .opB(opB), .isSub(isSub), .opSize(opSize), .aluResult_r(aluResult_r),
      .statusFlags_r(statusFlags_r), .flagsImage(flagsImage), .segLoad(segLoad),
      .segLoadIdx(segLoadIdx), .segLoadSel(segLoadSel), .segLoadDesc(segLoadDesc),
      .segReadIdx(segReadIdx), .segReadSel_r(segReadSel_r), .memValid(memValid),
      .memKind(memKind), .memDataSeg(memDataSeg), .memOffset(memOffset), .memLen(memLen),
      .memDone_r(memDone_r), .linearAddr_r(linearAddr_r), .limitFault_r(limitFault_r),
      .attrFault_r(attrFault_r), .faultVector_r(faultVector_r), .ctrlOp(ctrlOp),
      .ctrlIdx(ctrlIdx), .ctrlWrData(ctrlWrData), .ctrlRdData_r(ctrlRdData_r),
      .protMode(protMode), .pagingEnable(pagingEnable));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic print_verdict;
      $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic alu(input logic [31:0] a, b, input logic s, input
      flags_segment_pkg::op_size_t sz, input logic [31:0] res, input logic [3:0] fl);
      opA = a; opB = b; isSub = s; opSize = sz; aluValid = 1;
      @(negedge clk_sys) aluValid = 0;
      chk("result", aluResult_r, res);
      chk("flags", 32'(statusFlags_r), 32'(fl));
      chk("image", flagsImage, {25'h0, fl[3], 1'b0, fl[2], 1'b0, fl[1], 1'b0, fl[0]});
   endtask : alu

   task automatic mem(input flags_segment_pkg::ref_kind_t k, input logic [2:0] sg, input
      logic [31:0] off, input logic [2:0] len, input logic [31:0] lin, input logic lf, af);
      memKind = k; memDataSeg = sg; memOffset = off; memLen = len; memValid = 1;
      @(negedge clk_sys) memValid = 0;
      chk("done", 32'(memDone_r), 32'h1);
      chk("linear", linearAddr_r, lin);
      chk("limit", 32'(limitFault_r), 32'(lf));
      chk("attr", 32'(attrFault_r), 32'(af));
      chk("vector", 32'(faultVector_r), (lf | af) ? 32'h0000000D : 32'h0);
      @(negedge clk_sys) chk("done", 32'(memDone_r), 32'h0);
   endtask : mem

   task automatic ctl(input flags_segment_pkg::ctrl_op_t op, input logic [1:0] ix,
      input logic [31:0] d);
      ctrlOp = op; ctrlIdx = ix; ctrlWrData = d;
      @(negedge clk_sys) ctrlOp = flags_segment_pkg::CTRL_NONE;
   endtask : ctl

   task automatic rd(input flags_segment_pkg::ctrl_op_t op, input logic [1:0] ix,
      input logic [31:0] exp);
      ctl(op, ix, 32'h0);
      chk("ctrl read", ctrlRdData_r, exp);
   endtask : rd

   task automatic sld(input logic [2:0] ix, input logic [15:0] s);
      segLoadIdx = ix; segLoadSel = s; segLoad = 1;
      @(negedge clk_sys) segLoad = 0;
      segReadIdx = ix;
      @(negedge clk_sys) chk("selector", 32'(segReadSel_r), 32'(s));
   endtask : sld

   initial begin
      repeat (400) @(posedge clk_sys);
      mismatches++;
      print_verdict();
   end

   initial begin
      repeat (2) @(negedge clk_sys);
      reset_n = 1;
      chk("prot", 32'(protMode), 32'h0);
      chk("paging", 32'(pagingEnable), 32'h0);
      alu(32'hFF, 32'h01, 0, flags_segment_pkg::SIZE8, 32'h0, 4'b1111);
      alu(32'hFF, 32'h01, 0, flags_segment_pkg::SIZE16, 32'h100, 4'b0110);
      alu(32'h0, 32'h1, 1, flags_segment_pkg::SIZE32, 32'hFFFFFFFF, 4'b0111);
      alu(32'h12345670, 32'h3, 0, flags_segment_pkg::SIZE32, 32'h12345673, 4'b0000);
      alu(32'h8000, 32'h8000, 0, flags_segment_pkg::SIZE16, 32'h0, 4'b1011);
      alu(32'h10, 32'h01, 1, flags_segment_pkg::SIZE8, 32'h0F, 4'b0110);
      // Real mode: base is selector times 16, limit fixed at 64 Kbytes
      sld(3'h2, 16'h1234);
      mem(flags_segment_pkg::REF_READ, 3'h2, 32'h10, 3'h1, 32'h00012350, 0, 0);
      mem(flags_segment_pkg::REF_WRITE, 3'h2, 32'hFFFF, 3'h1, 32'h0002233F, 0, 0);
      mem(flags_segment_pkg::REF_READ, 3'h2, 32'hFFFF, 3'h2, 32'h0002233F, 1, 0);
      mem(flags_segment_pkg::REF_FETCH, 3'h2, 32'h100, 3'h1, 32'h100, 0, 0);
      // Control registers
      ctl(flags_segment_pkg::CTRL_LOAD, 2'h0, 32'hFFFFFFFF);
      rd(flags_segment_pkg::CTRL_STORE, 2'h0, 32'h8000001F);
      ctl(flags_segment_pkg::HALF_LOAD, 2'h0, 32'h0000FFE0);
      rd(flags_segment_pkg::CTRL_STORE, 2'h0, 32'h80000001);
      chk("paging", 32'(pagingEnable), 32'h1);
      rd(flags_segment_pkg::HALF_STORE, 2'h0, 32'h00000001);
      ctl(flags_segment_pkg::CTRL_LOAD, 2'h2, 32'hDEADBEEF);
      rd(flags_segment_pkg::CTRL_STORE, 2'h2, 32'hDEADBEEF);
      ctl(flags_segment_pkg::CTRL_LOAD, 2'h3, 32'h12345678);
      rd(flags_segment_pkg::CTRL_STORE, 2'h3, 32'h12345000);
      rd(flags_segment_pkg::CTRL_STORE, 2'h1, 32'h00000000);
      ctl(flags_segment_pkg::CTRL_LOAD, 2'h0, 32'h00000001);
      chk("paging", 32'(pagingEnable), 32'h0);
      chk("prot", 32'(protMode), 32'h1);
      // Protected mode: descriptors come from the table model
      sld(3'h0, 16'h0008);
      mem(flags_segment_pkg::REF_FETCH, 3'h5, 32'h20, 3'h4, 32'h00100020, 0, 0);
      mem(flags_segment_pkg::REF_FETCH, 3'h5, 32'hFFE, 3'h4, 32'h00100FFE, 1, 0);
      mem(flags_segment_pkg::REF_WRITE, 3'h0, 32'h0, 3'h1, 32'h00100000, 0, 1);
      sld(3'h2, 16'h0010);
      mem(flags_segment_pkg::REF_READ, 3'h2, 32'hFFFFFFFE, 3'h4, 32'h2, 1, 0);
      sld(3'h1, 16'h0018);
      mem(flags_segment_pkg::REF_STACK, 3'h2, 32'h0, 3'h1, 32'h0, 0, 1);
      // Clearing protection needs the full word load
      ctl(flags_segment_pkg::CTRL_LOAD, 2'h0, 32'h0);
      chk("prot", 32'(protMode), 32'h0);
      sld(3'h2, 16'h0010);
      mem(flags_segment_pkg::REF_READ, 3'h2, 32'h10000, 3'h1, 32'h00010100, 1, 0);
      mem(flags_segment_pkg::REF_READ, 3'h6, 32'h0, 3'h1, 32'h0, 0, 1);
      print_verdict();
   end
endmodule : flags_segment_control_state_bench
